// [logic/pci_pm_capability_regs.sv]
// Configuration-header tail and power-management capability registers, with
// the open-drain wake pin. Assumes the host bridge presents one configuration
// read or write per cycle on the PCI clock; aux_power_in is an asynchronous strap.
`timescale 1ns/10ps
module pci_pm_capability_regs (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        cfg_rd_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [5:0]  cfg_index_in,
  input  wire logic [3:0]  cfg_byte_en_in,
  input  wire logic [31:0] cfg_wdata_in,
  input  wire logic        wake_event_in,
  input  wire logic        aux_power_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_rvalid_out,
  output logic [1:0]       power_state_out,
  output logic             driver_wake_clear_out,
  output logic             wake_pin_data_out,
  output logic             wake_pin_oe_out
);

  // ==========================================================================
  // Reset release and strap synchroniser
  // ==========================================================================
  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       aux_meta;
  logic       aux_sync;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // The strap may move at any time, so it is read only after two flops.
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aux_meta <= 1'b0;
      aux_sync <= 1'b0;
    end
    else
    begin
      aux_meta <= aux_power_in;
      aux_sync <= aux_meta;
    end
  end

  // ==========================================================================
  // Writable state
  // ==========================================================================
  logic [7:0] int_line;
  logic       wake_sts;
  logic       wake_en;
  logic [3:0] data_sel;
  logic [1:0] power_state;
  logic       drv_clr;
  logic       pin_oe;
  logic [7:0] next_int_line;
  logic       next_wake_sts;
  logic       next_wake_en;
  logic [3:0] next_data_sel;
  logic [1:0] next_power_state;
  logic       next_drv_clr;
  logic       next_pin_oe;
  logic       wr_int;
  logic       wr_csr_lo;
  logic       wr_csr_hi;
  logic       sts_clear;

  assign wr_int    = cfg_wr_in && (cfg_index_in == pm_cap_pkg::IDX_INT) && cfg_byte_en_in[0];
  assign wr_csr_lo = cfg_wr_in && (cfg_index_in == pm_cap_pkg::IDX_POWER_CONTROL_STATUS) && cfg_byte_en_in[0];
  assign wr_csr_hi = cfg_wr_in && (cfg_index_in == pm_cap_pkg::IDX_POWER_CONTROL_STATUS) && cfg_byte_en_in[1];
  assign sts_clear = wr_csr_hi && cfg_wdata_in[pm_cap_pkg::STS_BIT];

  always_comb
  begin
    next_int_line    = int_line;
    next_wake_en     = wake_en;
    next_data_sel    = data_sel;
    next_power_state = power_state;
    if (wr_int)
      next_int_line = cfg_wdata_in[7:0];
    if (wr_csr_lo)
      next_power_state = cfg_wdata_in[pm_cap_pkg::STATE_HI:0];
    if (wr_csr_hi)
    begin
      next_wake_en  = cfg_wdata_in[pm_cap_pkg::EN_BIT];
      next_data_sel = cfg_wdata_in[pm_cap_pkg::SEL_HI:pm_cap_pkg::SEL_LO];
    end
    // A wake event in the clearing cycle is kept: the set wins.
    next_wake_sts = wake_event_in || (wake_sts && !sts_clear);
    next_drv_clr  = sts_clear;
    // The pin follows the flag only while enabled; a clear drops it too.
    next_pin_oe   = next_wake_sts && next_wake_en;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_line    <= pm_cap_pkg::INT_LINE_RST;
      wake_sts    <= 1'b0;
      wake_en     <= 1'b0;
      data_sel    <= pm_cap_pkg::SEL_RST;
      power_state <= pm_cap_pkg::STATE_D0;
      drv_clr     <= 1'b0;
      pin_oe      <= 1'b0;
    end
    else
    begin
      int_line    <= next_int_line;
      wake_sts    <= next_wake_sts;
      wake_en     <= next_wake_en;
      data_sel    <= next_data_sel;
      power_state <= next_power_state;
      drv_clr     <= next_drv_clr;
      pin_oe      <= next_pin_oe;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [31:0] rdata;
  logic        rvalid;
  logic [31:0] next_rdata;
  logic        next_rvalid;
  logic [15:0] csr_word;
  logic [1:0]  data_scale;

  // Scale follows the select register, not the value written alongside it.
  assign data_scale = (data_sel <= pm_cap_pkg::SEL_LAST) ?
                      pm_cap_pkg::SCALE_TBL : pm_cap_pkg::SCALE_NONE;

  always_comb
  begin
    // Unlisted bits, reserved and dynamic-data, stay zero.
    csr_word = 16'h0000;
    csr_word[pm_cap_pkg::STS_BIT] = wake_sts;
    csr_word[pm_cap_pkg::SCALE_HI:pm_cap_pkg::SCALE_LO] = data_scale;
    csr_word[pm_cap_pkg::SEL_HI:pm_cap_pkg::SEL_LO] = data_sel;
    csr_word[pm_cap_pkg::EN_BIT] = wake_en;
    csr_word[pm_cap_pkg::STATE_HI:0] = power_state;
  end

  // Only the stored fields above are written; constants cannot be overwritten.
  always_comb
  begin
    next_rvalid = cfg_rd_in;
    next_rdata  = 32'h0000_0000;
    if (cfg_rd_in)
    begin
      unique case (cfg_index_in)
        pm_cap_pkg::IDX_CAP_PTR:
          next_rdata = {24'h00_0000, pm_cap_pkg::CAP_PTR_VAL};
        pm_cap_pkg::IDX_INT:
          next_rdata = {pm_cap_pkg::MAX_LAT_VAL, pm_cap_pkg::MIN_GNT_VAL,
                        pm_cap_pkg::INT_PIN_VAL, int_line};
        pm_cap_pkg::IDX_PM_CAP:
          // Wake support, D1/D2, aux current, init, version sit in this word.
          next_rdata = {(aux_sync ? pm_cap_pkg::PMC_AUX : pm_cap_pkg::PMC_NOAUX),
                        pm_cap_pkg::NEXT_PTR_VAL,
                        pm_cap_pkg::CAP_ID_VAL};
        pm_cap_pkg::IDX_POWER_CONTROL_STATUS:
          next_rdata = {pm_cap_pkg::power_figure(data_sel), 8'h00, csr_word};
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata  <= 32'h0000_0000;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign cfg_rdata_out         = rdata;
  assign cfg_rvalid_out        = rvalid;
  assign power_state_out       = power_state;
  assign driver_wake_clear_out = drv_clr;
  // Open-drain: the pin is only ever pulled low, never driven high.
  assign wake_pin_data_out     = 1'b0;
  assign wake_pin_oe_out       = pin_oe;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  AST_CAP_PTR: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_CAP_PTR |=> cfg_rdata_out == 32'h0000_00DC)
    else $error("Capability pointer read wrong.");

  AST_HDR_TAIL: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_INT
      |=> cfg_rdata_out[31:8] == 24'h18_08_01 && cfg_rdata_out[7:0] == $past(int_line))
    else $error("Header tail read wrong.");

  AST_INT_LINE: assert property (
    wr_int |=> int_line == $past(cfg_wdata_in[7:0]))
    else $error("Interrupt line not stored.");

  AST_CAP_WORD: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP
      |=> cfg_rdata_out == ($past(aux_sync) ? 32'hFE21_0001 : 32'h7E21_0001))
    else $error("Capabilities word wrong.");

  AST_WAKE_SET: assert property (
    wake_event_in |=> wake_sts ##1 (wake_sts || $past(sts_clear)))
    else $error("Wake event lost.");

  AST_WAKE_CLR: assert property (
    sts_clear && !wake_event_in |=> !wake_sts && !wake_pin_oe_out && driver_wake_clear_out)
    else $error("Wake clear incomplete.");

  AST_PIN_GATE: assert property (
    wake_pin_oe_out |-> wake_en)
    else $error("Wake pin asserted while disabled.");

  AST_PIN_MIRROR: assert property (
    wake_en && wake_sts && !sts_clear && !(wr_csr_hi && !cfg_wdata_in[pm_cap_pkg::EN_BIT])
      |=> wake_pin_oe_out)
    else $error("Wake pin does not mirror status.");

  AST_SCALE: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_POWER_CONTROL_STATUS
      |=> cfg_rdata_out[14:13] == (($past(data_sel) < 4'h9) ? 2'h2 : 2'h0)
          && cfg_rdata_out[7:2] == 6'h00)
    else $error("Data scale or reserved bits wrong.");

  AST_STATE: assert property (
    wr_csr_lo |=> power_state_out == $past(cfg_wdata_in[1:0]) ##1
      (power_state_out == $past(power_state_out) || $past(wr_csr_lo)))
    else $error("Power state write not kept.");

  AST_MIN_GNT: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_INT |=> cfg_rdata_out[23:16] == 8'h08)
    else $error("Minimum grant read wrong.");

  AST_MAX_LAT: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_INT |=> cfg_rdata_out[31:24] == 8'h18)
    else $error("Maximum latency read wrong.");

  AST_CAP_ID: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[7:0] == 8'h01)
    else $error("Capability identifier read wrong.");

  AST_NEXT_PTR: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[15:8] == 8'h00)
    else $error("Next capability link not zero.");

  AST_WAKE_FIELD: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP && aux_sync
      |=> cfg_rdata_out[31:27] == 5'h1F)
    else $error("Wake support field wrong with auxiliary power.");

  AST_D1_D2: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[26:25] == 2'h3)
    else $error("D1 or D2 support bit wrong.");

  AST_AUX_CUR: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[24:22] == 3'h0)
    else $error("Auxiliary current field not zero.");

  AST_DSI: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[21] == 1'b1)
    else $error("Initialisation bit not set.");

  AST_PME_CLK: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_PM_CAP |=> cfg_rdata_out[20:19] == 2'h0)
    else $error("Bits 20 and 19 not zero.");

  AST_DATA_BYTE: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_POWER_CONTROL_STATUS && data_sel > pm_cap_pkg::SEL_LAST
      |=> cfg_rdata_out[31:24] == 8'h00)
    else $error("Data byte not zero for high select.");

  AST_DYN_DATA: assert property (
    cfg_rd_in && cfg_index_in == pm_cap_pkg::IDX_POWER_CONTROL_STATUS |=> cfg_rdata_out[4] == 1'b0)
    else $error("Dynamic data bit not zero.");

  AST_SEL_WR: assert property (
    wr_csr_hi |=> data_sel == $past(cfg_wdata_in[pm_cap_pkg::SEL_HI:pm_cap_pkg::SEL_LO]))
    else $error("Data select write not kept.");

  AST_EN_WR: assert property (
    wr_csr_hi |=> wake_en == $past(cfg_wdata_in[pm_cap_pkg::EN_BIT]))
    else $error("Wake enable write not kept.");

  AST_RO_WRITE: assert property (
    cfg_wr_in && cfg_index_in != pm_cap_pkg::IDX_INT && cfg_index_in != pm_cap_pkg::IDX_POWER_CONTROL_STATUS
      |=> $stable(int_line) && $stable(data_sel) && $stable(wake_en) && $stable(power_state))
    else $error("Write to a read-only location changed state.");

  AST_DRV_IDLE: assert property (
    !sts_clear |=> !driver_wake_clear_out)
    else $error("Driver wake clear pulsed without a clear.");

  COV_WAKE_PIN: cover property (wake_event_in ##1 wake_pin_oe_out);
  COV_CLEAR:    cover property (wake_sts && sts_clear ##1 driver_wake_clear_out);
  COV_D3:       cover property (wr_csr_lo ##1 power_state_out == 2'h3);
  COV_HI_SEL:   cover property (cfg_rd_in && data_sel > 4'h8);
  COV_SET_WINS: cover property (wake_event_in && sts_clear ##1 wake_sts);

endmodule

// [logic/pm_cap_pkg.sv]
// Constants for the configuration-header tail and power-management capability.
// Assumes configuration accesses address whole dwords by index with byte enables.
package pm_cap_pkg;

  // ==========================================================================
  // Dword indices in configuration space
  // ==========================================================================
  localparam logic [5:0] IDX_CAP_PTR = 6'h0D;
  localparam logic [5:0] IDX_INT     = 6'h0F;
  localparam logic [5:0] IDX_PM_CAP  = 6'h37;
  localparam logic [5:0] IDX_POWER_CONTROL_STATUS   = 6'h38;

  // ==========================================================================
  // Fixed values
  // ==========================================================================
  localparam logic [7:0]  CAP_PTR_VAL  = 8'hDC;
  localparam logic [7:0]  INT_PIN_VAL  = 8'h01;
  localparam logic [7:0]  MIN_GNT_VAL  = 8'h08;
  localparam logic [7:0]  MAX_LAT_VAL  = 8'h18;
  localparam logic [7:0]  CAP_ID_VAL   = 8'h01;
  localparam logic [7:0]  NEXT_PTR_VAL = 8'h00;
  localparam logic [15:0] PMC_AUX      = 16'hFE21;
  localparam logic [15:0] PMC_NOAUX    = 16'h7E21;
  localparam logic [7:0]  INT_LINE_RST = 8'h00;

  // ==========================================================================
  // Control/status field positions and values
  // ==========================================================================
  localparam int         STS_BIT     = 15;
  localparam int         EN_BIT      = 8;
  localparam int         SEL_LO      = 9;
  localparam int         SEL_HI      = 12;
  localparam int         SCALE_LO    = 13;
  localparam int         SCALE_HI    = 14;
  localparam int         STATE_HI    = 1;
  localparam int         DATA_LO     = 24;
  localparam logic [1:0] SCALE_TBL   = 2'h2;
  localparam logic [1:0] SCALE_NONE  = 2'h0;
  localparam logic [3:0] SEL_LAST    = 4'h8;
  localparam logic [3:0] SEL_RST     = 4'h0;
  localparam logic [1:0] STATE_D0    = 2'h0;

  typedef enum {ST_RUN} rd_phase_e;

  // Hard-coded power figures in units of 10 mW; selects above seven read zero.
  function automatic logic [7:0] power_figure(input logic [3:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      4'h0: v = 8'h3C;
      4'h1, 4'h2, 4'h3: v = 8'h2A;
      4'h4: v = 8'h3A;
      4'h5, 4'h6, 4'h7: v = 8'h28;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

endpackage

// [verif/host_cfg_model.sv]
// Host bridge model issuing configuration reads and writes.
// Assumes a free-running clock; requests launch on the falling edge.
`timescale 1ns/10ps
module host_cfg_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic        rvalid_in,
  output logic             rd_out,
  output logic             wr_out,
  output logic [5:0]       index_out,
  output logic [3:0]       be_out,
  output logic [31:0]      wdata_out
);
  // ==========================================================================
  // Idle bus
  // ==========================================================================
  initial
  begin
    rd_out    = 1'b0;
    wr_out    = 1'b0;
    index_out = 6'h3F;
    be_out    = 4'h0;
    wdata_out = 32'h0;
  end

  // ==========================================================================
  // Requests
  // ==========================================================================
  // Released qualifiers show inverted values so a stale latch cannot pass.
  task automatic cfg_write(input logic [5:0] idx, input logic [3:0] be,
                           input logic [31:0] d);
    @(negedge clk_in);
    wr_out    <= 1'b1;
    index_out <= idx;
    be_out    <= be;
    wdata_out <= d;
    @(negedge clk_in);
    wr_out    <= 1'b0;
    index_out <= ~idx;
    be_out    <= ~be;
    wdata_out <= ~d;
  endtask

  task automatic cfg_read(input logic [5:0] idx, output logic [31:0] d,
                          output logic ok);
    @(negedge clk_in);
    rd_out    <= 1'b1;
    index_out <= idx;
    @(negedge clk_in);
    rd_out    <= 1'b0;
    index_out <= ~idx;
    ok = 1'b0;
    d = 32'h0;
    repeat (4)
    begin
      if (!ok && rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_in;
      end
      if (!ok)
        @(negedge clk_in);
    end
  endtask
endmodule

// [verif/pci_pm_capability_regs_tb_top.sv]
// Self-checking bench for the power-management capability registers.
// Assumes the host model in host_cfg_model.sv and the design package.
`timescale 1ns/10ps
module pci_pm_capability_regs_tb_top;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        rd, wr, wake = 1'b0, aux = 1'b0;
  logic [5:0]  idx;
  logic [3:0]  be;
  logic [31:0] wd, rdata;
  logic        rvalid, drv_clr, pin_d, pin_oe;
  logic [1:0]  pstate;
  int          err_count = 0;
  int          compares = 0;

  always #2 clk_in = ~clk_in;

  host_cfg_model host_cfg_model_inst (.clk_in(clk_in), .rdata_in(rdata),
    .rvalid_in(rvalid), .rd_out(rd), .wr_out(wr), .index_out(idx),
    .be_out(be), .wdata_out(wd));

  pci_pm_capability_regs pci_pm_capability_regs_inst (.clk_in(clk_in),
    .rstn_in(rstn_in), .cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_index_in(idx),
    .cfg_byte_en_in(be), .cfg_wdata_in(wd), .wake_event_in(wake),
    .aux_power_in(aux), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
    .power_state_out(pstate), .driver_wake_clear_out(drv_clr),
    .wake_pin_data_out(pin_d), .wake_pin_oe_out(pin_oe));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdchk(input string nm, input logic [5:0] i, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    host_cfg_model_inst.cfg_read(i, d, ok);
    if (!ok)
    begin
      err_count++;
      wrap_up();
    end
    else
      chk(nm, d, exp);
  endtask

  task automatic csr_wr(input logic [3:0] b, input logic [31:0] d);
    host_cfg_model_inst.cfg_write(pm_cap_pkg::IDX_POWER_CONTROL_STATUS, b, d);
  endtask

  // Checks the current value first, as a pulse may already stand.
  task automatic seen(input bit pick, input logic v, output logic hit);
    hit = 1'b0;
    repeat (4)
    begin
      if ((pick ? drv_clr : pin_oe) === v)
        hit = 1'b1;
      @(negedge clk_in);
    end
  endtask

  task automatic pulse_wake;
    @(negedge clk_in);
    wake <= 1'b1;
    @(negedge clk_in);
    wake <= 1'b0;
  endtask

  function automatic logic [31:0] csr(logic [1:0] st, logic en, logic [3:0] sel, logic sts);
    logic [7:0] f;
    case (sel)
      4'h0: f = 8'h3C;
      4'h1, 4'h2, 4'h3: f = 8'h2A;
      4'h4: f = 8'h3A;
      4'h5, 4'h6, 4'h7: f = 8'h28;
      default: f = 8'h00;
    endcase
    return {f, 8'h00, sts, (sel <= 4'h8) ? 2'h2 : 2'h0, sel, en, 6'h00, st};
  endfunction

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_header;
    rdchk("csr_rst", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b0, 4'h0, 1'b0));
    rdchk("cap_ptr", pm_cap_pkg::IDX_CAP_PTR, 32'h0000_00DC);
    rdchk("int", pm_cap_pkg::IDX_INT, 32'h1808_0100);
    host_cfg_model_inst.cfg_write(pm_cap_pkg::IDX_INT, 4'hF, 32'hFFFF_FF5A);
    host_cfg_model_inst.cfg_write(pm_cap_pkg::IDX_CAP_PTR, 4'hF, 32'hFFFF_FFFF);
    host_cfg_model_inst.cfg_write(pm_cap_pkg::IDX_PM_CAP, 4'hF, 32'hFFFF_FFFF);
    rdchk("int_line", pm_cap_pkg::IDX_INT, 32'h1808_015A);
    rdchk("cap_ptr_ro", pm_cap_pkg::IDX_CAP_PTR, 32'h0000_00DC);
    rdchk("pm_cap", pm_cap_pkg::IDX_PM_CAP, 32'h7E21_0001);
    rdchk("unmapped", 6'h00, 32'h0);
    $display("done header");
  endtask

  task automatic t_aux;
    @(negedge clk_in);
    aux <= 1'b1;
    repeat (4) @(negedge clk_in);
    rdchk("pm_cap_aux", pm_cap_pkg::IDX_PM_CAP, 32'hFE21_0001);
    aux <= 1'b0;
    repeat (4) @(negedge clk_in);
    rdchk("pm_cap_pci", pm_cap_pkg::IDX_PM_CAP, 32'h7E21_0001);
    $display("done aux");
  endtask

  task automatic t_state;
    for (int s = 3; s >= 0; s--)
    begin
      csr_wr(4'h1, 32'h0000_00FC | s);
      rdchk("state", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(s, 1'b0, 4'h0, 1'b0));
      chk("state_pin", {30'h0, pstate}, s);
    end
    $display("done state");
  endtask

  task automatic t_select;
    for (int s = 15; s >= 0; s--)
    begin
      csr_wr(4'hA, 32'hFF00_6000 | (s << 9));
      rdchk("select", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b0, s, 1'b0));
    end
    $display("done select");
  endtask

  task automatic t_wake;
    logic h;
    pulse_wake();
    seen(1'b0, 1'b1, h);
    chk("pin_off", h, 1'b0);
    rdchk("sts_set", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b0, 4'h0, 1'b1));
    csr_wr(4'h2, 32'h0000_8000);
    seen(1'b1, 1'b1, h);
    chk("drv_clr", h, 1'b1);
    csr_wr(4'h2, 32'h0000_0100);
    rdchk("sts_clr", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b1, 4'h0, 1'b0));
    chk("pin_idle", pin_oe, 1'b0);
    pulse_wake();
    seen(1'b0, 1'b1, h);
    chk("pin_on", h, 1'b1);
    csr_wr(4'h2, 32'h0000_8100);
    seen(1'b0, 1'b0, h);
    chk("pin_clr", h, 1'b1);
    pulse_wake();
    csr_wr(4'h2, 32'h0000_0000);
    seen(1'b0, 1'b0, h);
    chk("pin_dis", h, 1'b1);
    // A wake event in the very cycle of a clear must survive it.
    fork
      pulse_wake();
      csr_wr(4'h2, 32'h0000_8100);
    join
    rdchk("sts_keep", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b1, 4'h0, 1'b1));
    chk("pin_keep", pin_oe, 1'b1);
    chk("pin_data", pin_d, 1'b0);
    $display("done wake");
  endtask

  task automatic t_reset;
    csr_wr(4'h3, 32'h0000_1303);
    @(negedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(negedge clk_in);
    chk("pin_rst", pin_oe, 1'b0);
    rstn_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    rdchk("csr_rst2", pm_cap_pkg::IDX_POWER_CONTROL_STATUS, csr(2'h0, 1'b0, 4'h0, 1'b0));
    rdchk("int_rst", pm_cap_pkg::IDX_INT, 32'h1808_0100);
    chk("state_rst", {30'h0, pstate}, 32'h0);
    $display("done reset");
  endtask

  initial
  begin
    repeat (2) @(negedge clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    t_header();
    t_aux();
    t_state();
    t_select();
    t_wake();
    t_reset();
    wrap_up();
  end
endmodule
